// *** rail_control_pg_delay_regs.sv ***
// Purpose: Mode, disable, enable-override and power-good delay registers
// Assumes: Register port is a simple byte strobe interface on REF_CLK
// Notes:   Reset values stand in for factory programmed configuration
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Bits 5..3 pick auto (0) or forced PWM (1) per step-down.
// - Bits 2..0 at 0 force the step-down off regardless of pins.
// - Switch/termination disable bits 7..4; 0 forces the rail off.
// - Pin b delay code at bits 7..5 picks 2.5 to 100 ms.
// - Pin d delay code at bits 4..2, same eight-step table.
// - Pin a delay code at bits 1..0 picks 0, 5, 10, 15 ms.
// - Delay starts once all grouped rails regulate; then power good.
// - Delays may vary ten percent; nominal is used here.
// - Outputs may be power good (timer) or register driven.
// - Override 1 forces step-down on unless disabled; 0 defers to pins.
module rail_control_pg_delay_regs #(
  parameter logic [7:0] INIT_MODE_DIS  = rail_ctrl_pkg::RST_MODE_DIS,
  parameter logic [7:0] INIT_POWER_GOOD_DELAY_TWO = rail_ctrl_pkg::RST_POWER_GOOD_DELAY_TWO,
  parameter logic [7:0] INIT_SW_DIS    = rail_ctrl_pkg::RST_SW_DIS,
  parameter logic [7:0] INIT_RAIL_EN1  = rail_ctrl_pkg::RST_RAIL_EN1,
  parameter int         CYC_PER_US     = rail_ctrl_pkg::CYC_PER_US
) (
  input  wire logic       REF_CLK,
  input  wire logic       RESET,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output var  logic [7:0] REG_RDATA,
  input  wire logic [2:0] PIN_CTRL_EN,
  input  wire logic [3:0] SW_PIN_EN,
  input  wire logic [2:0] GROUP_IN_REG,
  input  wire logic [2:0] OUT_FUNC_REG,
  input  wire logic [2:0] OUT_LEVEL,
  output var  logic [2:0] STEP_DOWN_FPWM,
  output var  logic [2:0] STEP_DOWN_ON,
  output var  logic [3:0] SWITCH_ON,
  output var  logic [2:0] OUT_PIN_GOOD
);

  // ==========================================================================
  // Register file
  logic [7:0] mode_dis_q, mode_dis_d;
  logic [7:0] dly_q, dly_d;
  logic [7:0] sw_dis_q, sw_dis_d;
  logic [7:0] rail_en_q, rail_en_d;
  logic [7:0] rdata_d;

  // Checks below all run on REF_CLK and sleep through reset
  default clocking cb_ref @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  always_comb begin
    mode_dis_d = mode_dis_q;
    dly_d      = dly_q;
    sw_dis_d   = sw_dis_q;
    rail_en_d  = rail_en_q;
    if (REG_WR) begin
      if (REG_ADDR == rail_ctrl_pkg::OFS_MODE_DIS) begin
        // writable mode and off bits, top two read zero
        mode_dis_d = REG_WDATA & rail_ctrl_pkg::MODE_DIS_MASK;
      end else if (REG_ADDR == rail_ctrl_pkg::OFS_POWER_GOOD_DELAY_TWO) begin
        dly_d = REG_WDATA;
      end else if (REG_ADDR == rail_ctrl_pkg::OFS_SW_DIS) begin
        // low nibble held at zero even if software misbehaves
        sw_dis_d = REG_WDATA & rail_ctrl_pkg::SW_DIS_MASK;
      end else if (REG_ADDR == rail_ctrl_pkg::OFS_RAIL_EN1) begin
        rail_en_d = REG_WDATA;
      end
    end
    rdata_d = 8'h00;
    if (REG_RD) begin
      if (REG_ADDR == rail_ctrl_pkg::OFS_MODE_DIS) begin
        rdata_d = mode_dis_q;
      end else if (REG_ADDR == rail_ctrl_pkg::OFS_POWER_GOOD_DELAY_TWO) begin
        rdata_d = dly_q;
      end else if (REG_ADDR == rail_ctrl_pkg::OFS_SW_DIS) begin
        rdata_d = sw_dis_q;
      end else if (REG_ADDR == rail_ctrl_pkg::OFS_RAIL_EN1) begin
        rdata_d = rail_en_q;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      mode_dis_q <= INIT_MODE_DIS & rail_ctrl_pkg::MODE_DIS_MASK;
      dly_q      <= INIT_POWER_GOOD_DELAY_TWO;
      sw_dis_q   <= INIT_SW_DIS & rail_ctrl_pkg::SW_DIS_MASK;
      rail_en_q  <= INIT_RAIL_EN1;
      REG_RDATA  <= 8'h00;
    end else begin
      mode_dis_q <= mode_dis_d;
      dly_q      <= dly_d;
      sw_dis_q   <= sw_dis_d;
      rail_en_q  <= rail_en_d;
      REG_RDATA  <= rdata_d;
    end
  end

  chk_mode_top_zero: assert property (mode_dis_q[7:6] == 2'b00)
    else $error("mode register top bits not zero");
  chk_sw_low_zero: assert property (sw_dis_q[3:0] == 4'h0)
    else $error("switch disable low bits not zero");

  // ==========================================================================
  // Pin synchronisers
  // Pins are asynchronous levels; two flops before any logic reads them
  logic [15:0] sync1_q, sync1_d;
  logic [15:0] sync2_q, sync2_d;
  logic [2:0]  pin_ctrl_s;
  logic [3:0]  sw_pin_s;
  logic [2:0]  group_s;
  logic [2:0]  func_s;
  logic [2:0]  level_s;

  always_comb begin
    sync1_d = {PIN_CTRL_EN, SW_PIN_EN, GROUP_IN_REG, OUT_FUNC_REG,
               OUT_LEVEL};
    sync2_d = sync1_q;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  always_comb begin
    pin_ctrl_s = sync2_q[15:13];
    sw_pin_s   = sync2_q[12:9];
    group_s    = sync2_q[8:6];
    func_s     = sync2_q[5:3];
    level_s    = sync2_q[2:0];
  end

  // ==========================================================================
  // Rail enables
  rail_ctrl_pkg::step_ctrl_t step;
  logic [2:0] fpwm_d, step_on_d;
  logic [3:0] sw_on_d;

  always_comb begin
    step      = rail_ctrl_pkg::step_ctrl_t'(mode_dis_q[5:0]);
    fpwm_d    = step.mode_sel;
    // off bit wins, else override or pin request
    step_on_d = step.step_off_n & (rail_en_q[2:0] | pin_ctrl_s);
    // switch and termination off bits gate the pin request
    sw_on_d   = sw_dis_q[7:4] & sw_pin_s;
  end

  // ==========================================================================
  // Power-good delay timers, index 0 = pin a, 1 = pin b, 2 = pin d
  logic [2:0]                       good_d, good_q;
  logic [2:0][rail_ctrl_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0][rail_ctrl_pkg::CNT_W-1:0] target;

  always_comb begin
    // code to nominal delay; nominal within tolerance
    target[0] = rail_ctrl_pkg::CNT_W'(CYC_PER_US *
                rail_ctrl_pkg::DLY_A_US[dly_q[1:0]]);
    target[1] = rail_ctrl_pkg::CNT_W'(CYC_PER_US *
                rail_ctrl_pkg::DLY_US[dly_q[7:5]]);
    target[2] = rail_ctrl_pkg::CNT_W'(CYC_PER_US *
                rail_ctrl_pkg::DLY_US[dly_q[4:2]]);
  end

  for (genvar i = 0; i < 3; i++) begin : g_pg
    always_comb begin
      cnt_d[i]  = cnt_q[i];
      good_d[i] = 1'b0;
      // count only while every grouped rail regulates
      if (!group_s[i]) begin
        cnt_d[i] = '0;
      end else if (cnt_q[i] >= target[i]) begin
        good_d[i] = 1'b1;
      end else begin
        cnt_d[i] = cnt_q[i] + 1'b1;
      end
      // register driven pins bypass the timer
      if (!func_s[i]) begin
        good_d[i] = level_s[i];
      end
    end

    chk_good_needs_group: assert property (
      1'b1 |=> !($past(func_s[i]) && !$past(group_s[i]) && good_q[i]))
      else $error("power good raised while group out of regulation");
    chk_count_cleared: assert property (
      !group_s[i] |=> cnt_q[i] == '0)
      else $error("delay counter not cleared while group low");
    chk_level_follows: assert property (
      !func_s[i] |=> good_q[i] == $past(level_s[i]))
      else $error("register driven pin does not follow its level");
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cnt_q          <= '0;
      good_q         <= 3'h0;
      STEP_DOWN_FPWM <= 3'h0;
      STEP_DOWN_ON   <= 3'h0;
      SWITCH_ON      <= 4'h0;
    end else begin
      cnt_q          <= cnt_d;
      good_q         <= good_d;
      STEP_DOWN_FPWM <= fpwm_d;
      STEP_DOWN_ON   <= step_on_d;
      SWITCH_ON      <= sw_on_d;
    end
  end

  always_comb OUT_PIN_GOOD = good_q;

  chk_mode_follows: assert property (
    1'b1 |=> STEP_DOWN_FPWM == $past(mode_dis_q[5:3]))
    else $error("forced PWM outputs do not follow mode bits");
  chk_step_off_wins: assert property (
    1'b1 |=> (STEP_DOWN_ON & ~$past(mode_dis_q[2:0])) == 3'h0)
    else $error("step-down on while its off bit is clear");
  chk_switch_off_wins: assert property (
    1'b1 |=> (SWITCH_ON & ~$past(sw_dis_q[7:4])) == 4'h0)
    else $error("switch on while its off bit is clear");

  cov_sw_write: cover property (
    REG_WR && REG_ADDR == rail_ctrl_pkg::OFS_SW_DIS);
  cov_step_on: cover property (STEP_DOWN_ON != 3'h0);
  cov_good_rise: cover property ($rose(good_q[1]));

endmodule // rail_control_pg_delay_regs

`default_nettype wire

// *** rail_control_pg_delay_regs_test.sv ***
// Purpose: Self-checking bench for the rail control register bank
// Assumes: CYC_PER_US of 1, so a delay of N us lasts N cycles
// Notes:   Delays pass within ten percent plus a few cycles of pipeline
`timescale 1ns/10ps
`default_nettype none
module rail_control_pg_delay_regs_test;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [2:0] pin_en = 3'h0;
  logic [3:0] sw_en = 4'h0;
  logic [2:0] grp = 3'h0;
  logic [2:0] func = 3'h7;
  logic [2:0] lvl = 3'h0;
  logic [7:0] rdat;
  logic [2:0] fpwm;
  logic [2:0] on;
  logic [3:0] sw_on;
  logic [2:0] good;
  int         n_errors = 0;
  int         checks = 0;

  always #20 clk = ~clk;

  rail_control_pg_delay_regs #(.CYC_PER_US(1)) rail_control_pg_delay_regs_inst (
    .REF_CLK(clk), .RESET(rst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdat), .REG_RDATA(rdat),
    .PIN_CTRL_EN(pin_en), .SW_PIN_EN(sw_en), .GROUP_IN_REG(grp),
    .OUT_FUNC_REG(func), .OUT_LEVEL(lvl), .STEP_DOWN_FPWM(fpwm),
    .STEP_DOWN_ON(on), .SWITCH_ON(sw_on), .OUT_PIN_GOOD(good));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Strobes change just after the edge and hold through the taking edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    wr = 1'b1; addr = a; wdat = d;
    @(posedge clk); #1;
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk); #1;
    rd = 1'b1; addr = a;
    @(posedge clk); #1;
    rd = 1'b0;
    chk(rdat, exp);
  endtask

  // Counts cycles from group in regulation to good, bounded
  task automatic measure(input int b, input int exp_cyc);
    int n;
    n = 0;
    @(posedge clk); #1;
    grp[b] = 1'b1;
    while (good[b] !== 1'b1) begin
      @(posedge clk); #1;
      n++;
      if (n > exp_cyc * 11 / 10 + 10) begin
        n_errors++;
        $display("CHECK FAILED t=%0t got %0h exp %0h", $time, n, exp_cyc);
        tally_and_finish();
      end
    end
    chk(8'(n >= exp_cyc * 9 / 10 && n <= exp_cyc * 11 / 10 + 4), 8'h01);
    grp[b] = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(8'(good[b]), 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    rd_reg(8'h9C, 8'h07);
    rd_reg(8'h9D, 8'h12);
    rd_reg(8'h9F, 8'hF0);
    rd_reg(8'hA0, 8'h00);
    rd_reg(8'h9E, 8'h00);
    wr_reg(8'h9C, 8'hFF);
    rd_reg(8'h9C, 8'h3F);
    chk(8'(fpwm), 8'h07);
    pin_en = 3'h7;
    wr_reg(8'h9C, 8'h05);
    rd_reg(8'h9C, 8'h05);
    chk(8'(on), 8'h05);
    pin_en = 3'h0;
    wr_reg(8'hA0, 8'h07);
    rd_reg(8'hA0, 8'h07);
    chk(8'(on), 8'h05);
    sw_en = 4'hF;
    wr_reg(8'h9F, 8'h6F);
    rd_reg(8'h9F, 8'h60);
    chk(8'(sw_on), 8'h06);
    wr_reg(8'h9D, 8'h01);
    measure(0, 5000);
    measure(1, 2500);
    measure(2, 2500);
    wr_reg(8'h9D, 8'hA0);
    measure(0, 0);
    measure(1, 50000);
    func = 3'h0;
    lvl = 3'h5;
    repeat (4) @(posedge clk);
    #1;
    chk(8'(good), 8'h05);
    tally_and_finish();
  end
endmodule // rail_control_pg_delay_regs_test
`default_nettype wire

// *** rail_ctrl_pkg.sv ***
// Purpose: Shared constants and carriers for the rail control register bank
// Assumes: 25 MHz reference clock, byte-wide register port
// Notes:   Delay tables are in microseconds, converted to cycles with CYC_PER_US in the register module
package rail_ctrl_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_MODE_DIS   = 8'h9C;
  localparam logic [7:0] OFS_POWER_GOOD_DELAY_TWO  = 8'h9D;
  localparam logic [7:0] OFS_SW_DIS     = 8'h9F;
  localparam logic [7:0] OFS_RAIL_EN1   = 8'hA0;

  // ==========================================================================
  // Field positions
  localparam int MODE_LSB     = 3;
  localparam int STEP_OFF_LSB = 0;
  localparam int SW_OFF_LSB   = 4;
  localparam int DLY_B_LSB    = 5;
  localparam int DLY_D_LSB    = 2;
  localparam int DLY_A_LSB    = 0;

  // ==========================================================================
  // Values after reset and register write masks
  localparam logic [7:0] RST_MODE_DIS  = 8'h07;
  localparam logic [7:0] RST_POWER_GOOD_DELAY_TWO = 8'h12;
  localparam logic [7:0] RST_SW_DIS    = 8'hF0;
  localparam logic [7:0] RST_RAIL_EN1  = 8'h00;
  localparam logic [7:0] MODE_DIS_MASK = 8'h3F;
  localparam logic [7:0] SW_DIS_MASK   = 8'hF0;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int TIME_UNIT_US = 1;
  localparam int DLY_US [8]   = '{2500, 5000, 10000, 15000,
                                  20000, 50000, 75000, 100000};
  localparam int DLY_A_US [4] = '{0, 5000, 10000, 15000};
  localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
  localparam int CNT_W        = 22;

  typedef struct packed {
    logic [2:0] mode_sel;
    logic [2:0] step_off_n;
  } step_ctrl_t;

endpackage
